// file: design/rics_params.svh
/*
 constants of the reference input switch control block.
 assumes a 32-bit apb bus with 12-bit byte addresses.
*/
// Functional notes
// - modes 0,1,2 fix the active reference at input 0,1,2.
// - manual mode runs the selected input buffer even when disabled.
// - manual with holdover: lock loss enters holdover when disable bit is 0.
// - manual holdover exit is judged on the manually selected input.
// - mode 3 picks the reference from the two select pins.
// - in mode 3 any select pin change is a switch event.
// - disable bit set: lock loss causes no event and no holdover.
// - a select pin set as output reads as 0.
// - pins 00,01,10 select inputs 0,1,2; 11 forces holdover.
// - pin mode runs the selected buffer; software keeps candidates enabled.
// - pin mode without holdover switches at once on an event.
// - pin mode with holdover: hold, then switch to the pin choice.
// - mode 4 steps through enabled inputs in order 0,1,2.
// - automatic mode skips inputs whose enable bit is clear.
// - entering mode 4 keeps the active input while locked.
// - automatic: lock loss is an event; lock must return before another.
// - enabled tuning rail detection forces holdover; lock loss follows.
// - automatic with holdover: hold, advance, exit when new input qualifies.
// - each input has a pre-divider of 1, 2, 4 or 8.
// - input 1 may serve as feedback or oscillator input, then no candidate.
// - lock detect stays low during holdover.
// - holdover exits after the lock window holds for the hold count.
`ifndef RICS_PARAMS_SVH
`define RICS_PARAMS_SVH
`define RICS_CTRL_OFF 12'h000
`define RICS_PREDIV_OFF 12'h004
`define RICS_LOCK_OFF 12'h008
`define RICS_STATUS_OFF 12'h00c
`define RICS_CTRL_RST 32'h000007c0
`define RICS_PREDIV_RST 32'h00000000
`define RICS_LOCK_RST 32'h00100004
`define RICS_F_MODE 2:0
`define RICS_F_HOLD_EN 3
`define RICS_F_LLS_DIS 4
`define RICS_F_RAIL_EN 5
`define RICS_F_ENABLE 8:6
`define RICS_F_PIN_DIR 10:9
`define RICS_F_ALT1 11
`define RICS_F_WINDOW 7:0
`define RICS_F_HOLD_CNT 23:8
`define RICS_MODE_PIN 3'h3
`define RICS_MODE_AUTO 3'h4
`endif

// file: design/rics_pkg.sv
/*
 types of the reference input switch control block.
 assumes nothing beyond the params header.
*/
package rics_pkg;
   typedef enum logic [1:0] {
      RICS_TRACK = 2'b00,
      RICS_HOLD = 2'b01
   } rics_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } rics_apb_req_t;
endpackage

// file: design/rics_top.sv
/*
 reference input switch control: selects the loop-one reference among
 three inputs, handles holdover entry and exit, apb register file.
 assumes select pins, phase detector results and rail flags synchronous to pclk.
*/
`timescale 1ns/100ps
`include "rics_params.svh"
module rics_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire rics_pkg::rics_apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic select_pin_0,
   input wire logic select_pin_1,
   input wire logic pd_compare_valid,
   input wire logic [7:0] pd_phase_error,
   input wire logic tune_rail_high,
   input wire logic tune_rail_low,
   output logic [1:0] active_input,
   output logic [2:0] ref_buffer_enable,
   output logic [5:0] ref_prediv_code,
   output logic holdover,
   output logic loop1_lock_detect,
   output logic switch_event
);
   logic [31:0] ctrl;
   logic [31:0] prediv;
   logic [31:0] lockcfg;
   logic [31:0] next_ctrl;
   logic [31:0] next_prediv;
   logic [31:0] next_lockcfg;
   logic [31:0] next_prdata;
   logic mapped;
   logic wr;

   rics_pkg::rics_state_t state;
   rics_pkg::rics_state_t next_state;
   logic [1:0] next_active;
   logic [1:0] pending;
   logic [1:0] next_pending;
   logic [2:0] mode_prev;
   logic [1:0] pins_prev;
   logic lock_prev;
   logic armed;
   logic next_armed;
   logic [15:0] lock_cnt;
   logic [15:0] next_lock_cnt;
   logic evt;

   logic [2:0] mode;
   logic hold_en;
   logic lls_dis;
   logic rail_en;
   logic [2:0] en;
   logic [1:0] pin_dir;
   logic alt1;
   logic [1:0] pins_eff;
   logic [2:0] avail;
   logic [1:0] nxt;
   logic [1:0] first;
   logic qualified;
   logic lock_evt;
   logic mode_chg;
   logic pin_evt;
   logic forced;
   logic rail;
   logic exit_ok;

   assign mode = ctrl[`RICS_F_MODE];
   assign hold_en = ctrl[`RICS_F_HOLD_EN];
   assign lls_dis = ctrl[`RICS_F_LLS_DIS];
   assign rail_en = ctrl[`RICS_F_RAIL_EN];
   assign en = ctrl[`RICS_F_ENABLE];
   assign pin_dir = ctrl[`RICS_F_PIN_DIR];
   assign alt1 = ctrl[`RICS_F_ALT1];

   // apb slave: zero wait states, unmapped access answers with pslverr
   assign mapped = apb_req.paddr == `RICS_CTRL_OFF || apb_req.paddr == `RICS_PREDIV_OFF
      || apb_req.paddr == `RICS_LOCK_OFF || apb_req.paddr == `RICS_STATUS_OFF;
   assign pready = 1'b1;
   assign pslverr = apb_req.psel & apb_req.penable & ~mapped;
   assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;

   always_comb
   begin
      next_ctrl = ctrl;
      next_prediv = prediv;
      next_lockcfg = lockcfg;
      next_prdata = prdata;
      if (wr && apb_req.paddr == `RICS_CTRL_OFF)
         next_ctrl = {20'h00000, apb_req.pwdata[11:0]};
      if (wr && apb_req.paddr == `RICS_PREDIV_OFF)
         next_prediv = {26'h0000000, apb_req.pwdata[5:0]};
      if (wr && apb_req.paddr == `RICS_LOCK_OFF)
         next_lockcfg = {8'h00, apb_req.pwdata[23:0]};
      // read data is caught in the setup cycle so it leaves a flip-flop
      if (apb_req.psel && !apb_req.penable)
      begin
         case (apb_req.paddr)
            `RICS_CTRL_OFF: next_prdata = ctrl;
            `RICS_PREDIV_OFF: next_prdata = prediv;
            `RICS_LOCK_OFF: next_prdata = lockcfg;
            `RICS_STATUS_OFF: next_prdata = {18'h00000, lock_cnt == 16'hffff, armed,
               pins_eff, ref_buffer_enable, loop1_lock_detect, holdover, 1'b0,
               pending, active_input};
            default: next_prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= `RICS_CTRL_RST;
         prediv <= `RICS_PREDIV_RST;
         lockcfg <= `RICS_LOCK_RST;
         prdata <= 32'h00000000;
      end
      else
      begin
         ctrl <= next_ctrl;
         prediv <= next_prediv;
         lockcfg <= next_lockcfg;
         prdata <= next_prdata;
      end
   end

   // each two-bit code divides its input by 1, 2, 4 or 8
   assign ref_prediv_code = prediv[5:0];

   assign pins_eff = {pin_dir[1] & select_pin_1, pin_dir[0] & select_pin_0};
   // input 1 drops out of the candidates while it serves as feedback
   assign avail = {en[2], en[1] & ~alt1, en[0]};
   assign forced = mode == `RICS_MODE_PIN && pins_eff == 2'b11;
   assign rail = rail_en & (tune_rail_high | tune_rail_low);
   assign qualified = lock_cnt >= lockcfg[`RICS_F_HOLD_CNT];
   assign holdover = state == rics_pkg::RICS_HOLD;
   assign loop1_lock_detect = qualified & ~holdover;
   assign mode_chg = mode != mode_prev;
   assign pin_evt = mode == `RICS_MODE_PIN && !mode_chg && pins_eff != pins_prev;
   assign lock_evt = lock_prev & ~loop1_lock_detect & ~lls_dis & armed;
   // exit by qualified lock, or at once when software clears holdover enable
   assign exit_ok = ~forced & ~rail & (qualified | ~hold_en);

   always_comb
   begin
      int idx;
      idx = 0;
      nxt = active_input;
      first = active_input;
      for (int k = 3; k >= 1; k--)
      begin
         idx = (int'(active_input) + k) % 3;
         if (avail[idx])
         begin
            nxt = 2'(idx);
         end
      end
      for (int k = 2; k >= 0; k--)
      begin
         if (avail[k])
         begin
            first = 2'(k);
         end
      end
   end

   always_comb
   begin
      next_state = state;
      next_active = active_input;
      next_pending = pending;
      evt = 1'b0;
      if (mode_chg)
      begin
         case (mode)
            3'h0, 3'h1, 3'h2:
            begin
               next_active = mode[1:0];
               next_pending = mode[1:0];
            end
            `RICS_MODE_PIN:
            begin
               if (pins_eff != 2'b11)
               begin
                  next_active = pins_eff;
                  next_pending = pins_eff;
               end
            end
            `RICS_MODE_AUTO:
            begin
               if (!loop1_lock_detect)
               begin
                  next_active = first;
               end
            end
            default:
            begin
               next_active = active_input;
            end
         endcase
      end
      else
      begin
         case (mode)
            3'h0, 3'h1, 3'h2:
            begin
               if (hold_en && lock_evt)
               begin
                  evt = 1'b1;
                  next_state = rics_pkg::RICS_HOLD;
               end
            end
            `RICS_MODE_PIN:
            begin
               if (pin_evt || lock_evt)
               begin
                  evt = 1'b1;
                  if (pins_eff != 2'b11)
                  begin
                     next_pending = pins_eff;
                  end
                  if (hold_en || forced)
                  begin
                     next_state = rics_pkg::RICS_HOLD;
                  end
                  else
                  begin
                     next_active = pins_eff;
                  end
               end
            end
            `RICS_MODE_AUTO:
            begin
               if (lock_evt)
               begin
                  evt = 1'b1;
                  next_active = nxt;
                  next_pending = nxt;
                  if (hold_en)
                  begin
                     next_state = rics_pkg::RICS_HOLD;
                  end
               end
            end
            default: evt = 1'b0;
         endcase
      end
      case (state)
         rics_pkg::RICS_TRACK:
         begin
            if (forced || rail)
            begin
               next_state = rics_pkg::RICS_HOLD;
            end
         end
         rics_pkg::RICS_HOLD:
         begin
            // lock is judged on the active input, the manual one in manual mode
            if (exit_ok && next_state == rics_pkg::RICS_HOLD && !evt)
            begin
               next_state = rics_pkg::RICS_TRACK;
               if (mode == `RICS_MODE_PIN)
               begin
                  next_active = pending;
               end
            end
         end
         default:
         begin
            next_state = rics_pkg::RICS_TRACK;
         end
      endcase
   end

   // a new reference restarts the lock count
   always_comb
   begin
      next_lock_cnt = lock_cnt;
      if (evt || next_active != active_input)
         next_lock_cnt = 16'h0000;
      else if (pd_compare_valid && pd_phase_error > lockcfg[`RICS_F_WINDOW])
         next_lock_cnt = 16'h0000;
      else if (pd_compare_valid && lock_cnt != 16'hffff)
         next_lock_cnt = lock_cnt + 16'h0001;
      // a lock fall disarms unless the disable bit is set, also one that is not an event in its mode
      next_armed = armed;
      if (loop1_lock_detect)
         next_armed = 1'b1;
      else if (evt || lock_evt)
         next_armed = 1'b0;
   end

   // manual and pin modes force the chosen buffer on; auto obeys enables
   always_comb
   begin
      ref_buffer_enable = avail;
      if (mode <= `RICS_MODE_PIN)
      begin
         ref_buffer_enable = en;
         ref_buffer_enable[active_input] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= rics_pkg::RICS_TRACK;
         active_input <= 2'h0;
         pending <= 2'h0;
         mode_prev <= 3'h0;
         pins_prev <= 2'h0;
         lock_prev <= 1'b0;
         armed <= 1'b0;
         lock_cnt <= 16'h0000;
         switch_event <= 1'b0;
      end
      else
      begin
         state <= next_state;
         active_input <= next_active;
         pending <= next_pending;
         mode_prev <= mode;
         pins_prev <= pins_eff;
         lock_prev <= loop1_lock_detect;
         armed <= next_armed;
         lock_cnt <= next_lock_cnt;
         switch_event <= evt;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_manual_sel;
      mode <= 3'h2 && mode_prev == mode |-> active_input == mode[1:0];
   endproperty
   a_manual_sel: assert property (p_manual_sel) else $error("manual mode input wrong");

   property p_manual_buf;
      mode <= 3'h2 |-> ref_buffer_enable[active_input];
   endproperty
   a_manual_buf: assert property (p_manual_buf) else $error("manual buffer off");

   property p_lock_hold;
      mode <= 3'h2 && !mode_chg && hold_en && lock_evt |=> holdover ##0 switch_event;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("no holdover on lock loss");

   property p_pin_event;
      pin_evt |=> switch_event;
   endproperty
   a_pin_event: assert property (p_pin_event) else $error("pin change missed");

   property p_nohold_switch;
      pin_evt && !hold_en && pins_eff != 2'b11 && !holdover |=> active_input == $past(pins_eff);
   endproperty
   a_nohold_switch: assert property (p_nohold_switch) else $error("pin switch late");

   sequence s_pin_hold;
      pin_evt && hold_en ##1 holdover;
   endsequence
   property p_hold_then_switch;
      s_pin_hold ##1 !holdover |-> active_input == pending;
   endproperty
   a_hold_then_switch: assert property (p_hold_then_switch) else $error("switch not completed");

   property p_auto_skip;
      mode == `RICS_MODE_AUTO && !mode_chg && lock_evt && |avail && $stable(ctrl) |=> avail[active_input];
   endproperty
   a_auto_skip: assert property (p_auto_skip) else $error("disabled input chosen");

   property p_auto_entry;
      mode_chg && mode == `RICS_MODE_AUTO && loop1_lock_detect |=> $stable(active_input);
   endproperty
   a_auto_entry: assert property (p_auto_entry) else $error("auto entry moved input");

   property p_rearm;
      lock_evt |=> !armed ##0 !lock_evt;
   endproperty
   a_rearm: assert property (p_rearm) else $error("event without relock");

   property p_hold_exit;
      holdover && qualified && hold_en && !forced && !rail && !lock_evt |=> !holdover;
   endproperty
   a_hold_exit: assert property (p_hold_exit) else $error("holdover exit missed");

   sequence s_enter_hold;
      !holdover ##1 holdover;
   endsequence
   property p_hold_no_lock;
      s_enter_hold |-> !loop1_lock_detect ##1 (!loop1_lock_detect || !holdover);
   endproperty
   a_hold_no_lock: assert property (p_hold_no_lock) else $error("lock shown in holdover");
endmodule

// file: sim/rics_partner.sv
/*
 far-side model: phase-detector compares of the active reference, select pins
 and tuning rail flags.
 assumes the bench steers it through plain control inputs, changed on pclk.
*/
`timescale 1ns/100ps
module rics_partner (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic good,
   input wire logic [1:0] pins_req,
   input wire logic [1:0] rail_req,
   output logic select_pin_0,
   output logic select_pin_1,
   output logic pd_compare_valid,
   output logic [7:0] pd_phase_error,
   output logic tune_rail_high,
   output logic tune_rail_low
);
   logic [1:0] div;
   // one compare every four cycles; good sits exactly on a window of 8, bad one above it
   // between compares the error bus toggles so that a stale value never looks valid
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div <= 2'h0;
         pd_compare_valid <= 1'b0;
         pd_phase_error <= 8'h00;
         select_pin_0 <= 1'b0;
         select_pin_1 <= 1'b0;
         tune_rail_high <= 1'b0;
         tune_rail_low <= 1'b0;
      end
      else
      begin
         div <= div + 2'h1;
         pd_compare_valid <= (div == 2'h3);
         pd_phase_error <= (div == 2'h3) ? (good ? 8'h08 : 8'h09) : ~pd_phase_error;
         select_pin_0 <= pins_req[0];
         select_pin_1 <= pins_req[1];
         tune_rail_high <= rail_req[1];
         tune_rail_low <= rail_req[0];
      end
   end
endmodule

// file: sim/tb_top.sv
/*
 self-checking bench for the reference input switch control block.
 assumes the design package and params header are compiled first.
*/
`timescale 1ns/100ps
`include "rics_params.svh"
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   rics_pkg::rics_apb_req_t apb_req = '0;
   logic good = 1'b1;
   logic [1:0] pins_req = 2'h0;
   logic [1:0] rail_req = 2'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sp0;
   logic sp1;
   logic pd_valid;
   logic [7:0] pd_err;
   logic rail_hi;
   logic rail_lo;
   logic [1:0] active_input;
   logic [2:0] ref_buffer_enable;
   logic [5:0] ref_prediv_code;
   logic holdover;
   logic loop1_lock_detect;
   logic switch_event;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;

   always #10 pclk = ~pclk;

   rics_top dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .select_pin_0(sp0), .select_pin_1(sp1), .pd_compare_valid(pd_valid),
      .pd_phase_error(pd_err), .tune_rail_high(rail_hi), .tune_rail_low(rail_lo),
      .active_input(active_input), .ref_buffer_enable(ref_buffer_enable), .ref_prediv_code(ref_prediv_code),
      .holdover(holdover), .loop1_lock_detect(loop1_lock_detect), .switch_event(switch_event));

   rics_partner far (.pclk(pclk), .presetn(presetn), .good(good), .pins_req(pins_req), .rail_req(rail_req),
      .select_pin_0(sp0), .select_pin_1(sp1), .pd_compare_valid(pd_valid), .pd_phase_error(pd_err),
      .tune_rail_high(rail_hi), .tune_rail_low(rail_lo));

   task complete_run;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
      input logic eerr, input string name);
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      check({name, "_err"}, {31'h0, pslverr}, {31'h0, eerr});
      if (!w) check(name, prdata, exp);
      apb_req <= '0;
   endtask

   function automatic logic [31:0] ctrl(input logic [2:0] m, input logic h, input logic l, input logic r,
      input logic [2:0] en, input logic [1:0] dir, input logic a1);
      return {20'h0, a1, dir, en, r, l, h, m};
   endfunction

   task wr_ctrl(input logic [31:0] d);
      xfer(1'b1, `RICS_CTRL_OFF, d, 32'h0, 1'b0, "ctrl_write");
      repeat (2) @(posedge pclk);
      #1;
   endtask

   // sel 0 holdover, 1 lock detect, 2 switch event; bounded so a hang shows as a mismatch
   task wait_for(input int sel, input logic v, input string name);
      logic s;
      int n;
      s = ~v;
      n = 0;
      while (s !== v && n < 400)
      begin
         @(posedge pclk);
         #1;
         n++;
         s = (sel == 0) ? holdover : (sel == 1) ? loop1_lock_detect : switch_event;
      end
      check(name, {31'h0, s}, {31'h0, v});
   endtask

   task act(input logic [1:0] e);
      check("active_input", {30'h0, active_input}, {30'h0, e});
   endtask

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         complete_run;
      end
   end

   initial
   begin
      int i;
      logic [1:0] p;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b0, `RICS_CTRL_OFF, 32'h0, `RICS_CTRL_RST, 1'b0, "ctrl_rst");
      xfer(1'b0, `RICS_PREDIV_OFF, 32'h0, `RICS_PREDIV_RST, 1'b0, "prediv_rst");
      xfer(1'b0, `RICS_LOCK_OFF, 32'h0, `RICS_LOCK_RST, 1'b0, "lock_rst");
      xfer(1'b0, 12'h010, 32'h0, 32'h0, 1'b1, "unmapped_rd");
      xfer(1'b1, 12'h010, 32'hffffffff, 32'h0, 1'b1, "unmapped_wr");
      // short hold count keeps every relock at a few compares
      xfer(1'b1, `RICS_LOCK_OFF, 32'h00000408, 32'h0, 1'b0, "lock_wr");
      xfer(1'b0, `RICS_LOCK_OFF, 32'h0, 32'h00000408, 1'b0, "lock_rd");
      xfer(1'b1, `RICS_PREDIV_OFF, 32'h00000039, 32'h0, 1'b0, "prediv_wr");
      #1;
      check("prediv", {26'h0, ref_prediv_code}, 32'h39);
      for (i = 0; i < 3; i++)
      begin
         wr_ctrl(ctrl(i[2:0], 1'b0, 1'b0, 1'b0, 3'b000, 2'b11, 1'b0));
         act(i[1:0]);
         check("buf_manual", {29'h0, ref_buffer_enable}, 32'h1 << i);
      end
      wr_ctrl(ctrl(3'h1, 1'b1, 1'b0, 1'b0, 3'b111, 2'b11, 1'b0));
      wait_for(1, 1'b1, "lock_m");
      @(posedge pclk) good <= 1'b0;
      wait_for(0, 1'b1, "hold_m");
      check("lock_in_hold", {31'h0, loop1_lock_detect}, 32'h0);
      @(posedge pclk) good <= 1'b1;
      wait_for(0, 1'b0, "exit_m");
      act(2'h1);
      wr_ctrl(ctrl(3'h1, 1'b1, 1'b1, 1'b0, 3'b111, 2'b11, 1'b0));
      wait_for(1, 1'b1, "lock_d");
      @(posedge pclk) good <= 1'b0;
      repeat (40) @(posedge pclk);
      #1;
      check("hold_disabled", {31'h0, holdover}, 32'h0);
      @(posedge pclk) good <= 1'b1;
      wr_ctrl(ctrl(3'h3, 1'b0, 1'b1, 1'b0, 3'b000, 2'b11, 1'b0));
      for (i = 0; i < 3; i++)
      begin
         p = 2'((i + 1) % 3);
         @(posedge pclk) pins_req <= p;
         wait_for(2, 1'b1, "pin_event");
         act(p);
         check("buf_pin", {31'h0, ref_buffer_enable[p]}, 32'h1);
      end
      @(posedge pclk) pins_req <= 2'h3;
      wait_for(0, 1'b1, "pin_hold");
      wr_ctrl(ctrl(3'h3, 1'b0, 1'b1, 1'b0, 3'b000, 2'b00, 1'b0));
      wait_for(0, 1'b0, "pin_out_exit");
      act(2'h0);
      @(posedge pclk) pins_req <= 2'h0;
      wr_ctrl(ctrl(3'h3, 1'b1, 1'b1, 1'b0, 3'b111, 2'b11, 1'b0));
      wait_for(1, 1'b1, "lock_p");
      @(posedge pclk) pins_req <= 2'h2;
      wait_for(0, 1'b1, "pin_hold_en");
      act(2'h0);
      wait_for(0, 1'b0, "pin_exit");
      act(2'h2);
      // start automatic mode from a locked manual choice
      wr_ctrl(ctrl(3'h0, 1'b0, 1'b0, 1'b0, 3'b101, 2'b11, 1'b0));
      wait_for(1, 1'b1, "lock_a");
      wr_ctrl(ctrl(3'h4, 1'b0, 1'b0, 1'b0, 3'b101, 2'b11, 1'b0));
      act(2'h0);
      @(posedge pclk) good <= 1'b0;
      wait_for(2, 1'b1, "auto_event");
      act(2'h2);
      repeat (40) @(posedge pclk);
      #1;
      act(2'h2);
      @(posedge pclk) good <= 1'b1;
      wait_for(1, 1'b1, "relock_a");
      @(posedge pclk) good <= 1'b0;
      wait_for(2, 1'b1, "auto_event2");
      act(2'h0);
      @(posedge pclk) good <= 1'b1;
      wr_ctrl(ctrl(3'h4, 1'b1, 1'b0, 1'b0, 3'b111, 2'b11, 1'b1));
      wait_for(1, 1'b1, "lock_ah");
      @(posedge pclk) good <= 1'b0;
      wait_for(0, 1'b1, "auto_hold");
      @(posedge pclk) good <= 1'b1;
      wait_for(0, 1'b0, "auto_exit");
      act(2'h2);
      wr_ctrl(ctrl(3'h0, 1'b1, 1'b0, 1'b1, 3'b111, 2'b11, 1'b0));
      for (i = 0; i < 2; i++)
      begin
         wait_for(1, 1'b1, "lock_r");
         @(posedge pclk) rail_req <= (i == 0) ? 2'b10 : 2'b01;
         wait_for(0, 1'b1, "rail_hold");
         check("rail_lock", {31'h0, loop1_lock_detect}, 32'h0);
         @(posedge pclk) rail_req <= 2'b00;
         wait_for(0, 1'b0, "rail_exit");
      end
      complete_run;
   end
endmodule
